// File: rtl/timer_unit_pkg.sv
// Purpose: Shared constants and types of the timer unit
// Assumes: 32-bit register port, byte offsets multiple of four
// Notes:   Offsets, field positions, reset values, encodings
`default_nettype none
package timer_unit_pkg;
   // =========================================================
   // Register map
   localparam logic [7:0]  OFS_CTRL    = 8'h00;
   localparam logic [7:0]  OFS_STATUS  = 8'h04;
   localparam logic [7:0]  OFS_CMD     = 8'h08;
   localparam logic [7:0]  OFS_COUNT   = 8'h0c;
   localparam logic [7:0]  OFS_PERIOD  = 8'h10;
   localparam logic [7:0]  OFS_CC0     = 8'h14;
   localparam logic [7:0]  OFS_CC1     = 8'h18;
   // =========================================================
   // timer_main_control fields
   localparam int          BIT_SOFTWARE_RESET   = 0;
   localparam int          BIT_ENABLE  = 1;
   localparam int          BIT_RUNSTBY = 6;
   localparam int          BIT_ONREQ   = 7;
   localparam int          PRESC_LO    = 8;
   localparam int          BIT_AUTO_LOCK_UPDATE   = 11;
   localparam int          CHANNEL_CAPTURE_ENABLE_LO   = 16;
   localparam int          PINSEL_LO   = 20;
   localparam int          KIND0_LO    = 24;
   localparam int          KIND1_LO    = 27;
   localparam logic [31:0] CTRL_WMASK  = 32'h1b33_0ffe;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   // =========================================================
   // Status and command bits
   localparam int          STAT_STOP   = 0;
   localparam int          STAT_LOCK   = 1;
   localparam int          STAT_CLKREQ = 2;
   localparam int          STAT_BUSY   = 3;
   localparam int          CMD_RETRIG  = 0;
   localparam int          CMD_STOP    = 1;
   localparam int          CMD_LOCKCLR = 2;
   // =========================================================
   // Prescaler terminal counts for codes 0..7
   localparam logic [9:0]  PRESC_LAST [0:7] = '{
      10'h000, 10'h001, 10'h003, 10'h007,
      10'h00f, 10'h03f, 10'h0ff, 10'h3ff};
   // =========================================================
   // Types
   typedef enum logic [1:0] {
      capture_default  = 2'h0,
      capture_minimum  = 2'h1,
      capture_maximum  = 2'h2,
      capture_reserved = 2'h3
   } capture_kind_e;
   typedef enum logic [1:0] {
      RUN_ACTIVE  = 2'b01,
      RUN_STOPPED = 2'b10
   } run_state_e;
endpackage : timer_unit_pkg
`default_nettype wire

// File: rtl/timer_unit.sv
// Purpose: Timer/counter with main control register, two channels
// Assumes: One clock; pins asynchronous, events on this clock
// Notes:   Counter counts up to PERIOD, then wraps (overflow)
//
// How it works
// - Channel 1 capture kind bits 28:27: default, minimum, maximum, reserved
// - Channel 0 capture kind bits 25:24, same encoding as channel 1
// - Bits 20,21 choose capture trigger: 0 event network, 1 pin
// - Bits 16,17: 1 makes channel capture, 0 makes it compare
// - Auto-lock bit 11 sets lock flag on overflow or re-trigger
// - Bits 10:8 divide clock by 1,2,4,8,16,64,256,1024
// - Clock request stays on while stopped when on-request is clear
// - On-request set: stopped counter drops request until restart
// - Standby without run-in-standby forces on-request to zero
// - Bit 6 clear halts counter in standby, set keeps it running
// - Control settings act directly; no synchronisation busy
`timescale 1ns/1ps
`default_nettype none
module timer_unit
   import timer_unit_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input  wire logic              CLK,
   input  wire logic              SRST,
   // Register port
   input  wire logic [7:0]        ADDR,
   input  wire logic [31:0]       WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output var  logic [31:0]       RDATA,
   // Event network and pins
   input  wire logic              EV_START,
   input  wire logic [1:0]        EV_CAPT,
   input  wire logic [1:0]        CAP_PIN,
   input  wire logic              STANDBY,
   // Status outputs
   output var  logic              CLK_REQ,
   output var  logic [1:0]        MATCH,
   output var  logic [1:0]        CAPTURED
);
   import timer_unit_pkg::*;

   // =========================================================
   // Decode
   logic              wr_ctrl;
   logic              wr_cmd;
   logic              sw_reset;
   logic              clr;
   assign wr_ctrl  = WR && (ADDR == OFS_CTRL);
   assign wr_cmd   = WR && (ADDR == OFS_CMD);
   assign sw_reset = wr_ctrl && WDATA[BIT_SOFTWARE_RESET];
   assign clr      = SRST || sw_reset;

   // =========================================================
   // Control register
   logic [31:0]       ctrl_r;
   always_ff @(posedge CLK) begin
      if (clr) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= WDATA & CTRL_WMASK;
      end
   end

   logic              enable_f;
   logic              run_in_standby;
   logic              clock_on_request;
   logic [2:0]        prescaler_f;
   logic              auto_lock_update;
   logic [1:0]        channel_capture_enable;
   logic [1:0]        pin_capture_select;
   capture_kind_e     kind [2];
   assign enable_f               = ctrl_r[BIT_ENABLE];
   assign run_in_standby         = ctrl_r[BIT_RUNSTBY];
   assign clock_on_request       = ctrl_r[BIT_ONREQ];
   assign prescaler_f            = ctrl_r[PRESC_LO +: 3];
   assign auto_lock_update       = ctrl_r[BIT_AUTO_LOCK_UPDATE];
   assign channel_capture_enable = ctrl_r[CHANNEL_CAPTURE_ENABLE_LO +: 2];
   assign pin_capture_select     = ctrl_r[PINSEL_LO +: 2];
   assign kind[0] = capture_kind_e'(ctrl_r[KIND0_LO +: 2]);
   assign kind[1] = capture_kind_e'(ctrl_r[KIND1_LO +: 2]);

   // =========================================================
   // Standby and commands
   logic              sb_halt;
   logic              clock_on_request_eff;
   logic              retrig;
   logic              stop_cmd;
   logic              lock_clr;
   assign sb_halt      = STANDBY && !run_in_standby;
   assign clock_on_request_eff = clock_on_request && !sb_halt;
   assign retrig   = (wr_cmd && WDATA[CMD_RETRIG]) || EV_START;
   assign stop_cmd = wr_cmd && WDATA[CMD_STOP] && !retrig;
   assign lock_clr = wr_cmd && WDATA[CMD_LOCKCLR];

   // =========================================================
   // Run state
   run_state_e        state_r;
   always_ff @(posedge CLK) begin
      if (clr) begin
         state_r <= RUN_ACTIVE;
      end else begin
         case (state_r)
            RUN_ACTIVE: begin
               if (stop_cmd) begin
                  state_r <= RUN_STOPPED;
               end
            end
            RUN_STOPPED: begin
               if (retrig) begin
                  state_r <= RUN_ACTIVE;
               end
            end
            default: begin
               state_r <= RUN_ACTIVE;
            end
         endcase
      end
   end

   logic              counting;
   assign counting = enable_f && (state_r == RUN_ACTIVE) && !sb_halt;

   // =========================================================
   // Prescaler
   logic [9:0]        presc_r;
   logic              tick;
   assign tick = counting && (presc_r >= PRESC_LAST[prescaler_f]);
   always_ff @(posedge CLK) begin
      if (clr || retrig || tick) begin
         presc_r <= 10'h000;
      end else if (counting) begin
         presc_r <= presc_r + 10'h001;
      end
   end

   // =========================================================
   // Counter and period
   logic [CNT_W-1:0]  count_r;
   logic [CNT_W-1:0]  period_r;
   logic              ovf;
   assign ovf = tick && (count_r == period_r);
   always_ff @(posedge CLK) begin
      if (clr || retrig) begin
         count_r <= '0;
      end else if (WR && (ADDR == OFS_COUNT)) begin
         count_r <= WDATA[CNT_W-1:0];
      end else if (ovf) begin
         count_r <= '0;
      end else if (tick) begin
         count_r <= count_r + 1'b1;
      end
   end
   always_ff @(posedge CLK) begin
      if (clr) begin
         period_r <= '1;
      end else if (WR && (ADDR == OFS_PERIOD)) begin
         period_r <= WDATA[CNT_W-1:0];
      end
   end

   // =========================================================
   // Lock update flag, set wins over clear
   logic              lock_update_flag;
   always_ff @(posedge CLK) begin
      if (clr) begin
         lock_update_flag <= 1'b0;
      end else if (auto_lock_update && (ovf || retrig)) begin
         lock_update_flag <= 1'b1;
      end else if (lock_clr) begin
         lock_update_flag <= 1'b0;
      end
   end

   // =========================================================
   // Clock request
   always_ff @(posedge CLK) begin
      if (clr) begin
         CLK_REQ <= 1'b1;
      end else if (!clock_on_request_eff) begin
         CLK_REQ <= 1'b1;
      end else begin
         CLK_REQ <= (state_r == RUN_ACTIVE && !stop_cmd) || retrig;
      end
   end

   // =========================================================
   // Channels
   logic [CNT_W-1:0]  cc_r [2];
   logic [1:0]        take;
   logic [1:0]        store;
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         logic [2:0]  pin_sy_r;
         logic        pin_lvl_r;
         logic        pin_edge;
         logic        trig;
         logic        better;
         // Pin synchroniser, change once stages 2 and 3 agree
         always_ff @(posedge CLK) begin
            if (clr) begin
               pin_sy_r <= 3'h0;
            end else begin
               pin_sy_r <= {pin_sy_r[1:0], CAP_PIN[ch]};
            end
         end
         always_ff @(posedge CLK) begin
            if (clr) begin
               pin_lvl_r <= 1'b0;
            end else if (pin_sy_r[1] == pin_sy_r[2]) begin
               pin_lvl_r <= pin_sy_r[2];
            end
         end
         assign pin_edge = (pin_sy_r[1] == pin_sy_r[2]) &&
                           pin_sy_r[2] && !pin_lvl_r;
         assign trig = pin_capture_select[ch] ? pin_edge : EV_CAPT[ch];
         assign take[ch] = enable_f && channel_capture_enable[ch] && trig;
         always_comb begin
            case (kind[ch])
               capture_minimum: better = count_r < cc_r[ch];
               capture_maximum: better = count_r > cc_r[ch];
               default:         better = 1'b1;
            endcase
         end
         assign store[ch] = take[ch] && better;
         always_ff @(posedge CLK) begin
            if (clr) begin
               cc_r[ch] <= '0;
            end else if (store[ch]) begin
               cc_r[ch] <= count_r;
            end else if (WR && (ADDR == (ch == 0 ? OFS_CC0 : OFS_CC1)))
            begin
               cc_r[ch] <= WDATA[CNT_W-1:0];
            end
         end
         always_ff @(posedge CLK) begin
            if (clr) begin
               CAPTURED[ch] <= 1'b0;
               MATCH[ch]    <= 1'b0;
            end else begin
               CAPTURED[ch] <= store[ch];
               MATCH[ch]    <= !channel_capture_enable[ch] && tick &&
                               (count_r == cc_r[ch]);
            end
         end
      end
   endgenerate

   // =========================================================
   // Read port, data one cycle after strobe
   logic [31:0]       status_w;
   always_comb begin
      status_w              = 32'h0000_0000;
      status_w[STAT_STOP]   = (state_r == RUN_STOPPED);
      status_w[STAT_LOCK]   = lock_update_flag;
      status_w[STAT_CLKREQ] = CLK_REQ;
      status_w[STAT_BUSY]   = 1'b0;
   end
   always_ff @(posedge CLK) begin
      if (SRST || !RD) begin
         RDATA <= 32'h0000_0000;
      end else if (ADDR == OFS_CTRL) begin
         RDATA <= ctrl_r;
      end else if (ADDR == OFS_STATUS) begin
         RDATA <= status_w;
      end else if (ADDR == OFS_COUNT) begin
         RDATA <= 32'(count_r);
      end else if (ADDR == OFS_PERIOD) begin
         RDATA <= 32'(period_r);
      end else if (ADDR == OFS_CC0) begin
         RDATA <= 32'(cc_r[0]);
      end else if (ADDR == OFS_CC1) begin
         RDATA <= 32'(cc_r[1]);
      end else begin
         RDATA <= 32'h0000_0000;
      end
   end

   // =========================================================
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   a_software_reset_clears: assert property (
      sw_reset |=> (ctrl_r == CTRL_RST) && (count_r == '0))
      else $error("software reset did not clear registers");
   a_software_reset_reads_0: assert property (
      RD && (ADDR == OFS_CTRL) |=> !RDATA[BIT_SOFTWARE_RESET])
      else $error("software reset bit read back as one");
   a_presc_div1024: assert property (
      counting && (prescaler_f == 3'h7) |-> (tick == (presc_r == 10'h3ff)))
      else $error("divide by 1024 ticked at wrong count");
   a_presc_div1: assert property (
      counting && (prescaler_f == 3'h0) && !retrig && !WR && !ovf
      |=> (count_r == $past(count_r) + 1'b1))
      else $error("divide by 1 did not count every cycle");
   a_lock_auto_set: assert property (
      auto_lock_update && (ovf || retrig) && !sw_reset |=> lock_update_flag)
      else $error("auto-lock did not set lock flag");
   a_lock_untouched: assert property (
      !auto_lock_update && (ovf || retrig) && !lock_clr
      |=> $stable(lock_update_flag))
      else $error("lock flag changed without auto-lock");
   a_clkreq_kept: assert property (
      !clock_on_request && !wr_ctrl |=> CLK_REQ)
      else $error("clock request dropped with on-request clear");
   a_clkreq_dropped: assert property (
      (state_r == RUN_STOPPED) && clock_on_request_eff && !retrig && !wr_ctrl
      && !($past(STANDBY) != STANDBY) |=> !CLK_REQ)
      else $error("stopped counter kept requesting clock");
   a_clkreq_restart: assert property (
      clock_on_request_eff && retrig |=> CLK_REQ)
      else $error("re-trigger did not request clock");
   a_standby_force: assert property (
      sb_halt && !wr_ctrl |=> CLK_REQ)
      else $error("standby did not force on-request off");
   a_standby_halt: assert property (
      sb_halt && !retrig && !WR |=> $stable(count_r))
      else $error("counter moved while halted in standby");
   a_compare_only: assert property (
      !channel_capture_enable[0] && !wr_ctrl |=> !CAPTURED[0])
      else $error("compare channel captured");
   a_event_capture: assert property (
      enable_f && channel_capture_enable[0] && !pin_capture_select[0]
      && (kind[0] == capture_default) && EV_CAPT[0] |=> CAPTURED[0])
      else $error("event did not capture on channel 0");
   a_min_keeps: assert property (
      take[0] && (kind[0] == capture_minimum) && (count_r >= cc_r[0])
      && !WR |=> $stable(cc_r[0]))
      else $error("minimum capture overwrote smaller value");
   a_max_keeps: assert property (
      take[1] && (kind[1] == capture_maximum) && (count_r <= cc_r[1])
      && !WR |=> $stable(cc_r[1]))
      else $error("maximum capture overwrote larger value");
   a_no_busy: assert property (
      RD && (ADDR == OFS_STATUS) |=> !RDATA[STAT_BUSY])
      else $error("synchronisation busy reported");

   c_auto_lock: cover property (auto_lock_update && ovf);
   c_min_store: cover property (store[0] && kind[0] == capture_minimum);
   c_pin_capture: cover property (store[1] && pin_capture_select[1]);
   c_clk_drop: cover property (CLK_REQ ##1 !CLK_REQ);
endmodule : timer_unit
`default_nettype wire

// File: sim/event_net_model.sv
// Purpose: Event network and capture pin model
// Assumes: Tasks entered just after a rising edge
// Notes:   Pulses last one clock; pins are levels
`timescale 1ns/1ps
`default_nettype none
module event_net_model (
   // Clock
   input  wire logic       CLK,
   // Events and pins
   output var  logic       EV_START,
   output var  logic [1:0] EV_CAPT,
   output var  logic [1:0] CAP_PIN
);
   // ==========================================
   // Idle levels
   initial begin
      EV_START = 1'b0;
      EV_CAPT  = 2'h0;
      CAP_PIN  = 2'h0;
   end
   // ==========================================
   // Stimulus
   // start action pulse
   task automatic start_pulse();
      EV_START <= 1'b1;
      @(posedge CLK);
      EV_START <= 1'b0;
   endtask : start_pulse
   task automatic capt_pulse(input logic [1:0] m);
      EV_CAPT <= m;
      @(posedge CLK);
      EV_CAPT <= 2'h0;
   endtask : capt_pulse
   task automatic pin_set(input logic [1:0] p);
      CAP_PIN <= p;
   endtask : pin_set
endmodule : event_net_model
`default_nettype wire

// File: sim/testbench.sv
// Purpose: Self-checking bench of the timer unit
// Assumes: Tasks entered just after a rising edge
// Notes:   Counter stopped during captures for known values
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import timer_unit_pkg::*;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        standby = 1'b0;
   logic [31:0] rdata;
   logic        ev_start;
   logic        clk_req;
   logic [1:0]  ev_capt;
   logic [1:0]  cap_pin;
   logic [1:0]  match;
   logic [1:0]  captured;
   logic [1:0]  seen;
   logic [31:0] v;
   logic [31:0] dlt;
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   int          div_tab [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
   // ==========================================
   // Clock, timeout, instances
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   timer_unit dut (
      .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .EV_START(ev_start), .EV_CAPT(ev_capt),
      .CAP_PIN(cap_pin), .STANDBY(standby), .CLK_REQ(clk_req),
      .MATCH(match), .CAPTURED(captured));
   event_net_model net (
      .CLK(clk), .EV_START(ev_start), .EV_CAPT(ev_capt),
      .CAP_PIN(cap_pin));
   // ==========================================
   // Tasks
   task automatic conclude();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic bit_chk(input string n, input logic e, input logic g);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask : bit_chk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
   endtask : rd_reg
   task automatic rd_chk(input string n, input logic [7:0] a,
                         input logic [31:0] e);
      rd_reg(a, v);
      chk(n, e, v);
   endtask : rd_chk
   task automatic cmd(input int b);
      wr_reg(OFS_CMD, 32'h1 << b);
   endtask : cmd
   // Count advance over a span of cycles between two reads
   task automatic cnt_span(input int span, output logic [31:0] d);
      logic [31:0] a;
      logic [31:0] b;
      rd_reg(OFS_COUNT, a);
      repeat (span - 2) @(posedge clk);
      rd_reg(OFS_COUNT, b);
      d = b - a;
   endtask : cnt_span
   task automatic wait_req(input logic e);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         #1;
         if (clk_req === e) break;
      end
      bit_chk("clk_req", e, clk_req);
      @(posedge clk);
   endtask : wait_req
   task automatic capt(input logic [1:0] m, input logic [1:0] e);
      net.capt_pulse(m);
      #1 chk("captured", {30'h0, e}, {30'h0, captured});
      @(posedge clk);
   endtask : capt
   task automatic watch(input int n);
      seen = 2'h0;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         #1 seen = seen | captured | match;
      end
      @(posedge clk);
   endtask : watch
   // ==========================================
   // Sequence
   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd_chk("ctrl", OFS_CTRL, CTRL_RST);
      rd_chk("status", OFS_STATUS, 32'h0000_0004);
      rd_chk("unmapped", 8'h40, 32'h0);
      wr_reg(OFS_CTRL, 32'hffff_fffe);
      rd_chk("ctrl mask", OFS_CTRL, CTRL_WMASK);
      wr_reg(OFS_PERIOD, 32'h0000_1234);
      wr_reg(OFS_CTRL, 32'h0000_0001);
      rd_chk("ctrl srst", OFS_CTRL, 32'h0);
      rd_chk("period srst", OFS_PERIOD, 32'h0000_ffff);
      // Prescaler steps
      for (int p = 0; p < 8; p++) begin
         wr_reg(OFS_CTRL, 32'h2 | (32'(p) << PRESC_LO));
         cmd(CMD_RETRIG);
         cnt_span(4 * div_tab[p], dlt);
         chk("count step", 32'h4, dlt);
      end
      // Standby halt and run
      wr_reg(OFS_CTRL, 32'h2);
      standby <= 1'b1;
      cnt_span(10, dlt);
      chk("standby halt", 32'h0, dlt);
      wr_reg(OFS_CTRL, 32'h42);
      cnt_span(10, dlt);
      chk("standby run", 32'ha, dlt);
      standby <= 1'b0;
      // Auto lock
      wr_reg(OFS_PERIOD, 32'h10);
      cmd(CMD_RETRIG);
      cmd(CMD_LOCKCLR);
      repeat (40) @(posedge clk);
      rd_reg(OFS_STATUS, v);
      bit_chk("lock off", 1'b0, v[STAT_LOCK]);
      wr_reg(OFS_CTRL, 32'h802);
      cmd(CMD_LOCKCLR);
      repeat (40) @(posedge clk);
      rd_reg(OFS_STATUS, v);
      bit_chk("lock ovf", 1'b1, v[STAT_LOCK]);
      cmd(CMD_STOP);
      cmd(CMD_LOCKCLR);
      rd_reg(OFS_STATUS, v);
      bit_chk("lock clr", 1'b0, v[STAT_LOCK]);
      net.start_pulse();
      rd_reg(OFS_STATUS, v);
      bit_chk("lock trig", 1'b1, v[STAT_LOCK]);
      // Clock request
      wr_reg(OFS_CTRL, 32'h2);
      cmd(CMD_STOP);
      rd_reg(OFS_STATUS, v);
      bit_chk("stop", 1'b1, v[STAT_STOP]);
      bit_chk("busy", 1'b0, v[STAT_BUSY]);
      wait_req(1'b1);
      wr_reg(OFS_CTRL, 32'h82);
      wait_req(1'b0);
      net.start_pulse();
      wait_req(1'b1);
      cmd(CMD_STOP);
      wait_req(1'b0);
      cmd(CMD_RETRIG);
      wait_req(1'b1);
      cmd(CMD_STOP);
      standby <= 1'b1;
      wait_req(1'b1);
      wr_reg(OFS_CTRL, 32'hc2);
      wait_req(1'b0);
      standby <= 1'b0;
      // Min and max capture on a stopped counter
      wr_reg(OFS_COUNT, 32'h50);
      wr_reg(OFS_CTRL, 32'h1103_0002);
      capt(2'h3, 2'h2);
      rd_chk("cc0 min", OFS_CC0, 32'h0);
      rd_chk("cc1 max", OFS_CC1, 32'h50);
      wr_reg(OFS_COUNT, 32'h30);
      capt(2'h3, 2'h0);
      wr_reg(OFS_CC0, 32'h100);
      capt(2'h3, 2'h1);
      rd_chk("cc0 lower", OFS_CC0, 32'h30);
      // Default and reserved kinds store always
      for (int k = 0; k < 4; k += 3) begin
         wr_reg(OFS_COUNT, 32'h20 + 32'(k));
         wr_reg(OFS_CTRL, 32'h0900_0000 * 32'(k) + 32'h0003_0002);
         capt(2'h3, 2'h3);
         rd_chk("cc0 dflt", OFS_CC0, 32'h20 + 32'(k));
         rd_chk("cc1 dflt", OFS_CC1, 32'h20 + 32'(k));
      end
      // Pin trigger on channel 0 only
      wr_reg(OFS_CTRL, 32'h0013_0002);
      capt(2'h3, 2'h2);
      net.pin_set(2'h3);
      watch(8);
      chk("pin capture", 32'h1, {30'h0, seen});
      net.pin_set(2'h0);
      // Compare channels ignore triggers; channel 0 matches, channel 1 does not
      wr_reg(OFS_CTRL, 32'h2);
      wr_reg(OFS_PERIOD, 32'h20);
      wr_reg(OFS_CC0, 32'h10);
      cmd(CMD_RETRIG);
      capt(2'h3, 2'h0);
      watch(40);
      bit_chk("match0", 1'b1, seen[0]);
      bit_chk("match1", 1'b0, seen[1]);
      conclude();
   end
endmodule : testbench
`default_nettype wire
